// *** hdl/btr_pkg.sv ***
// Purpose: shared constants and carriers for the boot target register block
// Assumes: 40 MHz logic clock, word-wide command port from the bus engine
// Notes:   dac voltages are held in microvolts
package btr_pkg;

    localparam logic [7:0]  CMD_BOOT_TARGET   = 8'hd5;
    localparam int          CODE_LSB          = 0;
    localparam int          CODE_MSB          = 4;
    localparam int          SPARE_LSB         = 14;
    localparam int          SPARE_MSB         = 15;
    localparam logic [15:0] RO_MASK           = 16'h3fe0;
    localparam logic [15:0] RW_MASK           = 16'hc01f;
    localparam logic [4:0]  CODE_RESET        = 5'h00;
    localparam logic [1:0]  SPARE_RESET       = 2'h0;
    localparam logic [15:0] READ_IDLE         = 16'h0000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [15:0] wdata;
    } btr_req_type;

    typedef struct packed {
        logic        ack;
        logic        nack;
        logic        rvalid;
        logic [15:0] rdata;
    } btr_rsp_type;

    typedef struct packed {
        logic       soft_start;
        logic [4:0] scale_loop;
        logic [7:0] margin_high;
        logic [7:0] margin_low;
        logic [7:0] trim;
        logic [1:0] margin_sel;
    } btr_vout_cfg_type;

endpackage

// *** hdl/btr_dac_rom.sv ***
// Purpose: code to reference dac voltage table, registered read
// Assumes: code stable for one cycle before the value is used
// Notes:   values in microvolts, rounded to the nearest microvolt
`timescale 1ns/1ps
module btr_dac_rom (
    // clocking
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    // lookup
    input  wire logic [4:0]  i_code,
    output logic      [19:0] o_uv
);

    logic [19:0] table_uv;

    always_comb begin
        case (i_code)
            5'h00:   table_uv = 20'd0;
            5'h01:   table_uv = 20'd299805;
            5'h02:   table_uv = 20'd312500;
            5'h03:   table_uv = 20'd325195;
            5'h04:   table_uv = 20'd337891;
            5'h05:   table_uv = 20'd350100;
            5'h06:   table_uv = 20'd362305;
            5'h07:   table_uv = 20'd375000;
            5'h08:   table_uv = 20'd387695;
            5'h09:   table_uv = 20'd399900;
            5'h0a:   table_uv = 20'd412598;
            5'h0b:   table_uv = 20'd424805;
            5'h0c:   table_uv = 20'd437500;
            5'h0d:   table_uv = 20'd450195;
            5'h0e:   table_uv = 20'd462891;
            5'h0f:   table_uv = 20'd475100;
            5'h10:   table_uv = 20'd487305;
            5'h11:   table_uv = 20'd500000;
            5'h12:   table_uv = 20'd512695;
            5'h13:   table_uv = 20'd524900;
            5'h14:   table_uv = 20'd537109;
            5'h15:   table_uv = 20'd549805;
            5'h16:   table_uv = 20'd562500;
            5'h17:   table_uv = 20'd575195;
            5'h18:   table_uv = 20'd587891;
            5'h19:   table_uv = 20'd599609;
            5'h1a:   table_uv = 20'd625000;
            5'h1b:   table_uv = 20'd649900;
            5'h1c:   table_uv = 20'd674805;
            5'h1d:   table_uv = 20'd700195;
            5'h1e:   table_uv = 20'd724609;
            default: table_uv = 20'd750000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_uv <= 20'h00000;
        end else if (i_ce) begin
            o_uv <= table_uv;
        end
    end

endmodule

// *** hdl/btr_boot_target.sv ***
// Contract
// - The register answers at command D5h with word write and word read, unsigned binary.
// - Bits 13 to 5 are not implemented and always read as zero.
// - Bits 4 to 0 hold a writable boot target code used as the dac target for soft-start.
// - Code updates are accepted in every regulator state with no lockout.
// - A code change during soft-start moves the reference target so the output slews to it.
// - A write with any of bits 13 to 5 set is refused with a nack and leaves the register unchanged.
// - Such a refused write raises the comm fault bit and the invalid-data bit.
// - The code maps through a fixed 32-entry table from 0 V up to 0.75 V.
// - The effective boot voltage combines the code with loop scale, margin and trim settings.
//
// Purpose: boot target command register with dac target and boot voltage outputs
// Assumes: i_req is a one-cycle request from the bus engine, synchronous to i_clk
// Notes:   boot voltage is in microvolts, scaled by a power-of-two loop factor
`timescale 1ns/1ps
module btr_boot_target (
    // clocking
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    input  wire logic                      i_ce,
    // non-volatile backup
    input  wire logic                      i_nvm_load,
    input  wire logic [4:0]                i_nvm_code,
    input  wire logic [1:0]                i_nvm_spare,
    // command port
    input  wire btr_pkg::btr_req_type      i_req,
    output btr_pkg::btr_rsp_type           o_rsp,
    // output voltage settings
    input  wire btr_pkg::btr_vout_cfg_type i_vout_cfg,
    // fault flags, cleared by the status logic
    input  wire logic                      i_cml_clr,
    output logic                           o_status_cml,
    output logic                           o_cml_invalid_data,
    // regulator side
    output logic      [4:0]                o_boot_target_code,
    output logic      [1:0]                o_spare_saved_bits,
    output logic      [19:0]               o_boot_dac_voltage,
    output logic      [23:0]               o_boot_voltage,
    output logic                           o_ramp_retarget
);

    // previous published code and soft-start level, so back-to-back changes each retarget
    logic [4:0]  code_seen;
    logic        soft_seen;

    logic [4:0]  code;
    logic [1:0]  spare;
    logic [19:0] dac_uv;

    // address decode
    wire hit       = (i_req.cmd == btr_pkg::CMD_BOOT_TARGET);
    wire wr_hit    = i_req.wr && hit;
    wire rd_hit    = i_req.rd && hit;
    wire ro_touch  = |(i_req.wdata & btr_pkg::RO_MASK);
    wire wr_ok     = wr_hit && !ro_touch;
    wire wr_bad    = wr_hit && ro_touch;
    wire code_chg  = wr_ok && (i_req.wdata[btr_pkg::CODE_MSB:btr_pkg::CODE_LSB] != code);

    wire [15:0] read_word = {spare, 9'h000, code};

    function automatic logic [23:0] apply_margin(input logic [23:0] v, input logic [7:0] m);
        // margin and trim as signed per-mille offsets
        logic signed [33:0] prod;
        prod = $signed({10'h000, v}) * $signed({{26{m[7]}}, m});
        apply_margin = v + 24'(prod / 34'sd1000);
    endfunction

    logic [23:0] scaled;
    logic [7:0]  margin_pm;
    assign scaled    = 24'({4'h0, dac_uv} << i_vout_cfg.scale_loop[1:0]);
    assign margin_pm = (i_vout_cfg.margin_sel == 2'h1) ? i_vout_cfg.margin_high :
                       (i_vout_cfg.margin_sel == 2'h2) ? i_vout_cfg.margin_low : 8'h00;

    btr_dac_rom u_rom (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_code    (code),
        .o_uv      (dac_uv)
    );

    // published code moved while soft-start held
    wire retarget_now = i_vout_cfg.soft_start && soft_seen && (o_boot_target_code != code_seen);

    // reset constant, then backup load after release
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            code  <= btr_pkg::CODE_RESET;
            spare <= btr_pkg::SPARE_RESET;
        end else if (i_ce) begin
            if (i_nvm_load) begin
                code  <= i_nvm_code;
                spare <= i_nvm_spare;
            end else if (wr_ok) begin
                code  <= i_req.wdata[btr_pkg::CODE_MSB:btr_pkg::CODE_LSB];
                spare <= i_req.wdata[btr_pkg::SPARE_MSB:btr_pkg::SPARE_LSB];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsp <= '0;
        end else if (i_ce) begin
            o_rsp.ack    <= wr_ok || rd_hit;
            o_rsp.nack   <= wr_bad;
            o_rsp.rvalid <= rd_hit;
            o_rsp.rdata  <= rd_hit ? read_word : btr_pkg::READ_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status_cml       <= 1'b0;
            o_cml_invalid_data <= 1'b0;
        end else if (i_ce) begin
            o_status_cml       <= wr_bad || (o_status_cml && !i_cml_clr);
            o_cml_invalid_data <= wr_bad || (o_cml_invalid_data && !i_cml_clr);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            code_seen          <= btr_pkg::CODE_RESET;
            soft_seen          <= 1'b0;
            o_boot_target_code <= btr_pkg::CODE_RESET;
            o_spare_saved_bits <= btr_pkg::SPARE_RESET;
            o_boot_dac_voltage <= 20'h00000;
            o_boot_voltage     <= 24'h000000;
            o_ramp_retarget    <= 1'b0;
        end else if (i_ce) begin
            code_seen          <= o_boot_target_code;
            soft_seen          <= i_vout_cfg.soft_start;
            o_boot_target_code <= code;
            o_spare_saved_bits <= spare;
            o_boot_dac_voltage <= dac_uv;
            o_boot_voltage     <= apply_margin(apply_margin(scaled, margin_pm), i_vout_cfg.trim);
            o_ramp_retarget    <= retarget_now;
        end
    end

endmodule

// *** tb/btr_boot_target_sva.sv ***
// Purpose: port checker for the boot target register
// Assumes: one clock domain, i_ce high while requests run
// Notes:   ports grouped per line to stay compact
`timescale 1ns/1ps
module btr_boot_target_sva (
    input wire logic                      i_clk, i_sys_rst, i_ce, i_nvm_load, i_cml_clr,
    input wire logic [4:0]                i_nvm_code,
    input wire logic [1:0]                i_nvm_spare,
    input wire btr_pkg::btr_req_type      i_req,
    input wire btr_pkg::btr_rsp_type      o_rsp,
    input wire btr_pkg::btr_vout_cfg_type i_vout_cfg,
    input wire logic                      o_status_cml, o_cml_invalid_data, o_ramp_retarget,
    input wire logic [4:0]                o_boot_target_code,
    input wire logic [1:0]                o_spare_saved_bits,
    input wire logic [19:0]               o_boot_dac_voltage,
    input wire logic [23:0]               o_boot_voltage
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire hit  = i_ce && i_req.cmd == btr_pkg::CMD_BOOT_TARGET;
    wire bad  = hit && i_req.wr && (i_req.wdata & btr_pkg::RO_MASK) != 16'h0000;
    wire good = hit && i_req.wr && !bad && !i_nvm_load;
    chk_read_ack: assert property (hit && i_req.rd |=> o_rsp.ack && o_rsp.rvalid && !o_rsp.nack)
        else $error("read not acknowledged");
    chk_rsvd_zero: assert property (o_rsp.rvalid |-> o_rsp.rdata[13:5] == 9'h000)
        else $error("reserved bits not zero");
    chk_bad_nack: assert property (bad |=> o_rsp.nack && !o_rsp.ack)
        else $error("bad write not refused");
    chk_bad_flags: assert property (bad |-> ##[1:2] o_status_cml && o_cml_invalid_data)
        else $error("fault flags not raised");
    chk_bad_keep: assert property (bad && !i_nvm_load |-> ##2 o_boot_target_code == $past(o_boot_target_code))
        else $error("bad write changed code");
    chk_good_code: assert property (good |-> ##2 o_boot_target_code == $past(i_req.wdata[4:0], 2))
        else $error("written code not stored");
    chk_nvm_load: assert property (i_ce && i_nvm_load |-> ##2 {o_spare_saved_bits, o_boot_target_code}
        == $past({i_nvm_spare, i_nvm_code}, 2))
        else $error("backup not loaded");
    chk_dac_top: assert property (i_ce && o_boot_target_code == 5'h1f |=> o_boot_dac_voltage == 20'hb71b0)
        else $error("top code voltage wrong");
    chk_ramp_move: assert property (i_ce && i_vout_cfg.soft_start && $past(i_vout_cfg.soft_start)
        && o_boot_target_code != $past(o_boot_target_code) |=> o_ramp_retarget)
        else $error("no retarget on code change");
    chk_flag_hold: assert property (o_status_cml && !i_cml_clr |=> o_status_cml)
        else $error("fault flag dropped");
    cov_good: cover property (good);
    cov_bad: cover property (bad);
    cov_ramp: cover property (o_ramp_retarget);
endmodule
bind btr_boot_target btr_boot_target_sva chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_nvm_load(i_nvm_load), .i_cml_clr(i_cml_clr), .i_nvm_code(i_nvm_code), .i_nvm_spare(i_nvm_spare),
    .i_req(i_req), .o_rsp(o_rsp), .i_vout_cfg(i_vout_cfg), .o_status_cml(o_status_cml),
    .o_cml_invalid_data(o_cml_invalid_data), .o_ramp_retarget(o_ramp_retarget),
    .o_boot_target_code(o_boot_target_code), .o_spare_saved_bits(o_spare_saved_bits),
    .o_boot_dac_voltage(o_boot_dac_voltage), .o_boot_voltage(o_boot_voltage));

// *** tb/btr_host_model.sv ***
// Purpose: host side issuing single word transfers
// Assumes: requests launched on falling edges, one cycle long
// Notes:   released lines show inverted data so stale values never match
`timescale 1ns/1ps
module btr_host_model (
    input  wire logic                 i_clk,
    input  wire btr_pkg::btr_rsp_type i_rsp,
    output btr_pkg::btr_req_type      o_req
);
    btr_pkg::btr_rsp_type rsp;
    initial o_req = '0;
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
        @(negedge i_clk);
        o_req = '{wr, !wr, cmd, d};
        // answer stands for the cycle after the taking edge
        @(negedge i_clk);
        rsp = i_rsp;
        o_req = '{1'b0, 1'b0, ~cmd, ~d};
    endtask
endmodule

// *** tb/btr_boot_target_bench.sv ***
// Purpose: self-checking bench for the boot target register
// Assumes: host model drives the command port
// Notes:   table voltages in microvolts, rounded
`timescale 1ns/1ps
module btr_boot_target_bench;
    logic                      i_clk = 0, i_sys_rst = 1, i_ce = 1, i_nvm_load = 0, i_cml_clr = 0;
    logic [4:0]                i_nvm_code = 5'h11;
    logic [1:0]                i_nvm_spare = 2'h2;
    btr_pkg::btr_req_type      req;
    btr_pkg::btr_rsp_type      rsp;
    btr_pkg::btr_vout_cfg_type cfg = '0;
    logic                      cml, ivd, rt;
    logic [4:0]                code;
    logic [1:0]                spare;
    logic [19:0]               dac;
    logic [23:0]               vb;
    int                        n_errors = 0, checks_done = 0;
    logic [15:0]               wd [4] = '{16'h4011, 16'h0001, 16'hc01f, 16'h0000};
    logic [19:0]               dv [4] = '{20'h7a120, 20'h4931d, 20'hb71b0, 20'h00000};
    always #12.5 i_clk = ~i_clk;
    btr_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
    btr_boot_target uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_nvm_load(i_nvm_load),
        .i_nvm_code(i_nvm_code), .i_nvm_spare(i_nvm_spare), .i_req(req), .o_rsp(rsp), .i_vout_cfg(cfg),
        .i_cml_clr(i_cml_clr), .o_status_cml(cml), .o_cml_invalid_data(ivd), .o_boot_target_code(code),
        .o_spare_saved_bits(spare), .o_boot_dac_voltage(dac), .o_boot_voltage(vb), .o_ramp_retarget(rt));
    task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic edge1;
        @(posedge i_clk);
        #1;
    endtask
    initial begin
        repeat (3000) @(posedge i_clk);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge i_clk);
        @(negedge i_clk) i_sys_rst = 0;
        host.xfer(1'b0, 8'hd5, 16'h0000);
        check("reset word", 24'h0, host.rsp.rdata);
        @(negedge i_clk) i_nvm_load = 1;
        @(negedge i_clk) i_nvm_load = 0;
        host.xfer(1'b0, 8'hd5, 16'h0000);
        check("backup word", 24'h8011, host.rsp.rdata);
        check("spare bits", 24'h2, spare);
        check("backup code", 24'h11, code);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, 8'hd5, wd[i]);
            check("write ack", 24'h1, host.rsp.ack);
            edge1();
            edge1();
            check("dac voltage", dv[i], dac);
            host.xfer(1'b0, 8'hd5, 16'h0000);
            check("read word", wd[i], host.rsp.rdata);
        end
        $display("test table done");
        host.xfer(1'b1, 8'hd5, 16'h0011);
        for (int i = 0; i < 2; i++) begin
            host.xfer(1'b1, 8'hd5, i ? 16'h2000 : 16'h003f);
            check("nack", 24'h1, {host.rsp.ack, host.rsp.nack});
            edge1();
            check("fault flags", 24'h3, {cml, ivd});
            host.xfer(1'b0, 8'hd5, 16'h0000);
            check("kept word", 24'h0011, host.rsp.rdata);
            @(negedge i_clk) i_cml_clr = 1;
            @(negedge i_clk) i_cml_clr = 0;
            check("flags cleared", 24'h0, {cml, ivd});
        end
        host.xfer(1'b1, 8'hd4, 16'h0001);
        check("other command", 24'h0, {host.rsp.ack, host.rsp.nack});
        $display("test refusal done");
        // host picks a loop gain of two
        @(negedge i_clk) cfg = '{1'b1, 5'h01, 8'h00, 8'h00, 8'h00, 2'h0};
        host.xfer(1'b1, 8'hd5, 16'h0001);
        check("soft-start ack", 24'h1, host.rsp.ack);
        edge1();
        edge1();
        check("retarget", 24'h1, rt);
        edge1();
        check("boot voltage", 24'h09263a, vb);
        $display("test soft-start done");
        summarize();
    end
endmodule
